// >>> tcspr_map.vh
`ifndef TCSPR_MAP_VH
`define TCSPR_MAP_VH

// Word offsets of the register map (byte addresses, low eight address bits).
`define TCSPR_OFS_CTRL      8'h00
`define TCSPR_OFS_COUNT     8'h10
`define TCSPR_OFS_MASK      8'h1C
`define TCSPR_OFS_RAW       8'h20
`define TCSPR_OFS_MSKD      8'h24
`define TCSPR_OFS_ACK       8'h28
`define TCSPR_OFS_PRESC     8'h2C
`define TCSPR_OFS_WIDTH     8'h30
`define TCSPR_OFS_PERIOD    8'h34

// Control register bits.
`define TCSPR_CTL_START     0
`define TCSPR_CTL_STOP      1
`define TCSPR_CTL_UPDATE    2

// Event bit positions, shared by mask, raw, masked and acknowledge registers.
`define TCSPR_EV_START      0
`define TCSPR_EV_STOP       1
`define TCSPR_EV_PSTART     2
`define TCSPR_EV_PEND       3
`define TCSPR_EV_MATCH      4
`define TCSPR_EV_OVF        5
`define TCSPR_EV_CAPT       6
`define TCSPR_EV_W          7

// Prescaler field positions.
`define TCSPR_PRESCALE_DIVISOR_HI       14
`define TCSPR_PRESCALE_DIVISOR_LO       4
`define TCSPR_POWER_OF_TWO_SHIFT_HI       3
`define TCSPR_POWER_OF_TWO_SHIFT_LO       0

// Width field position and reset values.
`define TCSPR_SIZE_HI       4
`define TCSPR_SIZE_RST      5'h0F
`define TCSPR_PRESCALE_DIVISOR_RST      11'h000
`define TCSPR_POWER_OF_TWO_SHIFT_RST      4'h0
`define TCSPR_PERIOD_RST    32'h00000000

`endif

// >>> tcspr_top.v
`include "tcspr_map.vh"
`default_nettype none

module tcspr_top (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata_q,
    output reg         hreadyout_q,
    output reg         hresp_q,
    input  wire        capture_pin,
    input  wire        pulse_match_in,
    output reg  [31:0] count_q,
    output reg         count_tick_q,
    output reg         irq_q
);

    // Bus state and register storage.
    reg         wr_q;
    reg  [7:0]  waddr_q;
    reg  [6:0]  mask_q;
    reg  [6:0]  raw_q;
    reg  [6:0]  raw_d;
    reg         running_q;
    reg  [10:0] prescale_divisor_h_q;
    reg  [3:0]  power_of_two_shift_h_q;
    reg  [4:0]  size_h_q;
    reg  [31:0] period_h_q;
    reg  [10:0] prescale_divisor_a_q;
    reg  [3:0]  power_of_two_shift_a_q;
    reg  [4:0]  size_a_q;
    reg  [31:0] period_a_q;
    reg  [10:0] pre_q;
    reg  [14:0] pow_q;
    reg         cap_s1_q;
    reg         cap_s2_q;
    reg         cap_s3_q;
    reg  [31:0] rd_d;

    wire        take      = hsel & hready & htrans[1];
    wire        rd_take   = take & ~hwrite;
    wire        wr_ctrl   = wr_q & (waddr_q == `TCSPR_OFS_CTRL);
    wire        start_pls = wr_ctrl & hwdata[`TCSPR_CTL_START];
    wire        stop_pls  = wr_ctrl & hwdata[`TCSPR_CTL_STOP] & ~hwdata[`TCSPR_CTL_START];
    wire        apply     = start_pls | (wr_ctrl & hwdata[`TCSPR_CTL_UPDATE]);
    wire [6:0]  ack_clr   = (wr_q & (waddr_q == `TCSPR_OFS_ACK)) ? hwdata[6:0] : 7'h00;
    wire [6:0]  rd_clr    = (rd_take & (haddr[7:0] == `TCSPR_OFS_RAW)) ? 7'h7F : 7'h00;

    // Prescaler terminal: the power-of-two stage rolls over after 2^shift divisor periods.
    wire [14:0] pow_mask  = ~(15'h7FFF << power_of_two_shift_a_q);
    wire        pre_end   = (pre_q == prescale_divisor_a_q);
    wire        tick      = running_q & pre_end & (pow_q == pow_mask);

    // Counter limits from the applied width and period.
    wire [31:0] wmax      = 32'hFFFFFFFF >> (5'h1F - size_a_q);
    wire        pend_hit  = tick & (period_a_q != 32'h00000000) & (count_q == period_a_q);
    wire        ovf_hit   = tick & ~pend_hit & (count_q == wmax);
    wire        cap_edge  = cap_s2_q & ~cap_s3_q;

    wire [6:0]  events    = {cap_edge, ovf_hit, pulse_match_in & running_q, pend_hit,
                             pend_hit | start_pls, stop_pls & running_q, start_pls};

    // Raw status: a new event wins over an acknowledge or read clear in the same cycle.
    always @* begin
        raw_d = (raw_q & ~ack_clr & ~rd_clr) | events;
    end

    // Read data multiplexer, evaluated in the address phase.
    always @* begin
        rd_d = 32'h00000000;
        case (haddr[7:0])
            `TCSPR_OFS_CTRL:   rd_d = {31'h00000000, running_q};
            `TCSPR_OFS_COUNT:  rd_d = count_q;
            `TCSPR_OFS_MASK:   rd_d = {25'h0000000, mask_q};
            `TCSPR_OFS_RAW:    rd_d = {25'h0000000, raw_q};
            `TCSPR_OFS_MSKD:   rd_d = {25'h0000000, mask_q & raw_q};
            `TCSPR_OFS_PRESC:  rd_d = {17'h00000, prescale_divisor_h_q, power_of_two_shift_h_q};
            `TCSPR_OFS_WIDTH:  rd_d = {27'h0000000, size_h_q};
            `TCSPR_OFS_PERIOD: rd_d = period_h_q;
            default:           rd_d = 32'h00000000;
        endcase
    end

    // Bus slave: zero wait states, always OKAY, write data taken in the data phase.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q        <= 1'b0;
            waddr_q     <= 8'h00;
            hrdata_q    <= 32'h00000000;
            hreadyout_q <= 1'b0;
            hresp_q     <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
            wr_q        <= take & hwrite;
            if (take) begin
                waddr_q <= haddr[7:0];
            end
            if (rd_take) begin
                hrdata_q <= rd_d;
            end
        end
    end

    // Mask and holding registers written by software; the counter does not see them yet.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q     <= 7'h00;
            prescale_divisor_h_q   <= `TCSPR_PRESCALE_DIVISOR_RST;
            power_of_two_shift_h_q   <= `TCSPR_POWER_OF_TWO_SHIFT_RST;
            size_h_q   <= `TCSPR_SIZE_RST;
            period_h_q <= `TCSPR_PERIOD_RST;
        end else if (wr_q) begin
            case (waddr_q)
                `TCSPR_OFS_MASK: begin
                    mask_q <= hwdata[6:0];
                end
                `TCSPR_OFS_PRESC: begin
                    prescale_divisor_h_q <= hwdata[`TCSPR_PRESCALE_DIVISOR_HI:`TCSPR_PRESCALE_DIVISOR_LO];
                    power_of_two_shift_h_q <= hwdata[`TCSPR_POWER_OF_TWO_SHIFT_HI:`TCSPR_POWER_OF_TWO_SHIFT_LO];
                end
                `TCSPR_OFS_WIDTH: begin
                    size_h_q <= hwdata[`TCSPR_SIZE_HI:0];
                end
                `TCSPR_OFS_PERIOD: begin
                    period_h_q <= hwdata;
                end
                default: begin
                    mask_q <= mask_q;
                end
            endcase
        end
    end

    // Applied settings copy the holding registers only on update or start.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescale_divisor_a_q   <= `TCSPR_PRESCALE_DIVISOR_RST;
            power_of_two_shift_a_q   <= `TCSPR_POWER_OF_TWO_SHIFT_RST;
            size_a_q   <= `TCSPR_SIZE_RST;
            period_a_q <= `TCSPR_PERIOD_RST;
        end else if (apply) begin
            prescale_divisor_a_q   <= prescale_divisor_h_q;
            power_of_two_shift_a_q   <= power_of_two_shift_h_q;
            size_a_q   <= size_h_q;
            period_a_q <= period_h_q;
        end
    end

    // Two-stage divider: divisor stage, then power-of-two stage.
    // A zero divisor with a nonzero shift is left to software to avoid.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= 11'h000;
            pow_q <= 15'h0000;
        end else if (apply || !running_q) begin
            pre_q <= 11'h000;
            pow_q <= 15'h0000;
        end else if (pre_end) begin
            pre_q <= 11'h000;
            pow_q <= (pow_q == pow_mask) ? 15'h0000 : pow_q + 15'h0001;
        end else begin
            pre_q <= pre_q + 11'h001;
        end
    end

    // Counter runs inside the applied width and wraps at the period or the width limit.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q      <= 32'h00000000;
            count_tick_q <= 1'b0;
            running_q    <= 1'b0;
        end else begin
            count_tick_q <= tick;
            if (start_pls) begin
                running_q <= 1'b1;
                count_q   <= 32'h00000000;
            end else if (stop_pls) begin
                running_q <= 1'b0;
            end else if (pend_hit || ovf_hit) begin
                count_q <= 32'h00000000;
            end else if (tick) begin
                count_q <= (count_q + 32'h00000001) & wmax;
            end
        end
    end

    // Capture pin synchroniser with edge detector after the second stage.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_s1_q <= 1'b0;
            cap_s2_q <= 1'b0;
            cap_s3_q <= 1'b0;
        end else begin
            cap_s1_q <= capture_pin;
            cap_s2_q <= cap_s1_q;
            cap_s3_q <= cap_s2_q;
        end
    end

    // Sticky status and the level interrupt.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            raw_q <= 7'h00;
            irq_q <= 1'b0;
        end else begin
            raw_q <= raw_d;
            irq_q <= |(raw_q & mask_q);
        end
    end

endmodule // tcspr_top

`default_nettype wire

// >>> tcspr_props.sv
`include "tcspr_map.vh"
`default_nettype none
module tcspr_props (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata_q,
    input wire logic        hreadyout_q,
    input wire logic        hresp_q,
    input wire logic [31:0] count_q,
    input wire logic        irq_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tk;
    logic ctl_q;
    logic msk_q;
    // A request is taken when selected, ready and NONSEQ or SEQ.
    assign tk = hsel && hready && htrans[1];
    // Marks a control write in data phase and whether the mask was ever written.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_q <= 1'b0;
            msk_q <= 1'b0;
        end else begin
            ctl_q <= tk && hwrite && haddr[7:0] == `TCSPR_OFS_CTRL;
            msk_q <= msk_q || (tk && hwrite && haddr[7:0] == `TCSPR_OFS_MASK);
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_ok; $past(hresetn) |-> hreadyout_q && !hresp_q; endproperty
    a_ok: assert property (p_ok) else $error("bus answer wrong");
    property p_ack; $past(tk && !hwrite && haddr[7:0] == `TCSPR_OFS_ACK) |-> hrdata_q == 32'h0; endproperty
    a_ack: assert property (p_ack) else $error("ack read not zero");
    property p_div; $past(tk && !hwrite && haddr[7:0] == `TCSPR_OFS_PRESC) |-> hrdata_q[31:15] == 17'h0; endproperty
    a_div: assert property (p_div) else $error("prescaler spare bits");
    property p_wid; $past(tk && !hwrite && haddr[7:0] == `TCSPR_OFS_WIDTH) |-> hrdata_q[31:5] == 27'h0; endproperty
    a_wid: assert property (p_wid) else $error("width spare bits");
    property p_hold; !$past(tk && !hwrite) |-> $stable(hrdata_q); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_start; ctl_q && hwdata[`TCSPR_CTL_START] |=> count_q == 32'h0; endproperty
    a_start: assert property (p_start) else $error("start kept count");
    property p_step; $changed(count_q) |-> count_q == $past(count_q) + 32'h1 || count_q == 32'h0; endproperty
    a_step: assert property (p_step) else $error("count jumped");
    property p_irq; !msk_q |-> !irq_q; endproperty
    a_irq: assert property (p_irq) else $error("irq while all masked");
    c_irq: cover property (irq_q);
    c_wrap: cover property ($changed(count_q) && count_q == 32'h0);
    c_start: cover property (ctl_q && hwdata[`TCSPR_CTL_START]);
endmodule // tcspr_props
bind tcspr_top tcspr_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata_q(hrdata_q),
    .hreadyout_q(hreadyout_q), .hresp_q(hresp_q), .count_q(count_q), .irq_q(irq_q));
`default_nettype wire

// >>> tcspr_tb_top.sv
`include "tcspr_map.vh"
`default_nettype none
module tcspr_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cap = 1'b0, pm = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, m;
    logic [1:0]  htrans = 2'h0;
    wire logic [31:0] hrdata_q, count_q;
    wire logic   hreadyout_q, hresp_q, tick, irq_q;
    int          n_mismatch = 0, cmp_count = 0;
    // Free-running 200 MHz clock.
    always #2.5 hclk = ~hclk;
    tcspr_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_q), .hrdata_q(hrdata_q),
        .hreadyout_q(hreadyout_q), .hresp_q(hresp_q), .capture_pin(cap), .pulse_match_in(pm),
        .count_q(count_q), .count_tick_q(tick), .irq_q(irq_q));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One single AHB transfer; waits for ready in both phases.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout_q !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout_q !== 1'b1);
        m = hrdata_q;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(m, e);
    endtask
    // Counts ticks and tick pulses over n clocks after the divider has settled, sampled mid-cycle.
    task automatic rate(input int n, input logic [31:0] e);
        logic [31:0] c0;
        logic [31:0] nt;
        nt = 32'h0;
        repeat (8) @(negedge hclk);
        c0 = count_q;
        repeat (n) begin
            @(negedge hclk);
            if (tick === 1'b1) nt = nt + 32'h1;
        end
        chk(count_q - c0, e);
        chk(nt, e);
    endtask
    // Highest count seen in a window after settling.
    task automatic peak(input logic [31:0] e);
        logic [31:0] mx;
        mx = 32'h0;
        repeat (12) @(negedge hclk);
        repeat (24) begin
            @(negedge hclk);
            if (count_q > mx) mx = count_q;
        end
        chk(mx, e);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        #50000;
        n_mismatch++;
        conclude();
    end
    // Main sequence.
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`TCSPR_OFS_PRESC, 32'h0);
        rd(`TCSPR_OFS_WIDTH, 32'hF);
        rd(`TCSPR_OFS_PERIOD, 32'h0);
        wr(8'h3C, 32'hFFFFFFFF);
        rd(8'h3C, 32'h0);
        rd(`TCSPR_OFS_ACK, 32'h0);
        wr(`TCSPR_OFS_PERIOD, 32'hA5A55A5A);
        rd(`TCSPR_OFS_PERIOD, 32'hA5A55A5A);
        wr(`TCSPR_OFS_PERIOD, 32'hFFFF0000);
        $display("test map done");
        wr(`TCSPR_OFS_CTRL, 32'h1);
        wr(`TCSPR_OFS_PRESC, 32'h10);
        rate(8, 32'h8);
        wr(`TCSPR_OFS_CTRL, 32'h4);
        rate(8, 32'h4);
        wr(`TCSPR_OFS_PRESC, 32'h11);
        rd(`TCSPR_OFS_PRESC, 32'h11);
        wr(`TCSPR_OFS_CTRL, 32'h4);
        rate(16, 32'h4);
        $display("test divider done");
        wr(`TCSPR_OFS_PRESC, 32'h0);
        wr(`TCSPR_OFS_WIDTH, 32'h2);
        wr(`TCSPR_OFS_CTRL, 32'h1);
        peak(32'h7);
        wr(`TCSPR_OFS_PERIOD, 32'h3);
        peak(32'h7);
        wr(`TCSPR_OFS_CTRL, 32'h4);
        peak(32'h3);
        $display("test width done");
        pm <= 1'b1;
        cap <= 1'b1;
        @(posedge hclk);
        pm <= 1'b0;
        wr(`TCSPR_OFS_CTRL, 32'h2);
        repeat (8) @(posedge hclk);
        wr(`TCSPR_OFS_MASK, 32'h0F);
        rd(`TCSPR_OFS_MSKD, 32'h0F);
        chk({31'h0, irq_q}, 32'h1);
        wr(`TCSPR_OFS_MASK, 32'h7F);
        wr(`TCSPR_OFS_ACK, 32'h0);
        rd(`TCSPR_OFS_MSKD, 32'h7F);
        wr(`TCSPR_OFS_ACK, 32'h0F);
        rd(`TCSPR_OFS_MSKD, 32'h70);
        wr(`TCSPR_OFS_ACK, 32'h70);
        rd(`TCSPR_OFS_MSKD, 32'h0);
        chk({31'h0, irq_q}, 32'h0);
        $display("test events done");
        conclude();
    end
endmodule // tcspr_tb_top
`default_nettype wire
